/* hwdt_chk.sv */
// Port checker for the hardware watchdog
`timescale 1ns/10ps
module hwdt_chk #(parameter int PULSE_CYCLES = hwdt_pkg::RESET_PULSE_CYCLES) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire hwdt_pkg::hwdt_sfr_type sfr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic enabled_o,
    input wire logic wdt_reset_n_o
);
    logic arm_q;
    logic [7:0] low_q;
    wire logic w6 = sfr_i.wr && sfr_i.addr == 8'hA6;
    wire logic go = w6 && sfr_i.wdata == 8'hE1 && arm_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arm_q <= 1'b0;
            low_q <= 8'h00;
        end else begin
            arm_q <= w6 ? sfr_i.wdata == 8'h1E : arm_q;
            low_q <= wdt_reset_n_o ? 8'h00 : low_q + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_en; go |=> enabled_o; endproperty
    a_en: assert property (p_en) else $error("service did not enable");
    property p_off; !enabled_o && !go |=> !enabled_o; endproperty
    a_off: assert property (p_off) else $error("enable without sequence");
    property p_hit; sfr_hit_o == (sfr_i.addr inside {8'hA6, 8'hA7}); endproperty
    a_hit: assert property (p_hit) else $error("bad decode");
    property p_rd6; sfr_i.addr == 8'hA6 |-> sfr_rdata_o == 8'h00; endproperty
    a_rd6: assert property (p_rd6) else $error("service reads data");
    property p_rd7; sfr_i.addr == 8'hA7 |-> sfr_rdata_o[7:3] == 5'h00; endproperty
    a_rd7: assert property (p_rd7) else $error("upper bits set");
    property p_sel; sfr_i.wr && sfr_i.addr == 8'hA7 ##1 sfr_i.addr == 8'hA7 && wdt_reset_n_o
        |-> sfr_rdata_o[2:0] == $past(sfr_i.wdata[2:0]); endproperty
    a_sel: assert property (p_sel) else $error("select not stored");
    property p_pulse; $rose(wdt_reset_n_o) |-> low_q == PULSE_CYCLES; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");
    property p_ovf; $fell(wdt_reset_n_o) |-> $past(enabled_o) && !enabled_o; endproperty
    a_ovf: assert property (p_ovf) else $error("reset without enabled overflow");
endmodule

/* hwdt_core.sv */
// Hardware watchdog: service sequence, timeout select, counter and reset pulse
//
// Overview of operation
// - Writing 1Eh then E1h to the service register enables or restarts the watchdog.
// - Service register at A6h is write only and reads back nothing.
// - Select field clears to 000 on reset; upper five bits are not stored.
// - Counter halts during power-down since power_down_i gates its count enable.
// - Power-down exits by hardware reset or enabled level external interrupt.
// - After interrupt wake, counting waits until the interrupt pin returns high.
// - Watchdog keeps counting in idle; software wakes periodically to service it.
// - Disabled after reset; once enabled only reset or overflow stops it.
// - Fourteen-bit base counter overflows past 3FFFh; software cannot access it.
// - Overflow drives an active-low reset pulse of 96 clock periods.
`timescale 1ns/10ps
module hwdt_core #(
    parameter int PULSE_CYCLES = hwdt_pkg::RESET_PULSE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire hwdt_pkg::hwdt_sfr_type sfr_i,
    input wire logic power_down_i,
    input wire logic wake_int_n_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    output logic enabled_o,
    output logic wdt_reset_n_o
);
    localparam int CW = hwdt_pkg::BASE_WIDTH + hwdt_pkg::PRESCALE_WIDTH;
    localparam int PW = hwdt_pkg::PULSE_CNT_WIDTH;

    // Pulse length must fit the pulse counter
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > (2 ** PW) - 1) begin : g_pulse_range
        $error("PULSE_CYCLES out of range");
    end

    // Limit arithmetic works in 64 bits
    if (CW > 63) begin : g_width_range
        $error("counter too wide for the limit arithmetic");
    end

    // Address decode shared by the write and read paths
    function automatic logic is_service(input logic [7:0] addr);
        return addr == hwdt_pkg::SERVICE_ADDR;
    endfunction

    function automatic logic is_select(input logic [7:0] addr);
        return addr == hwdt_pkg::SELECT_ADDR;
    endfunction

    // Terminal count 2^(14+sel)-1 of the combined counter
    function automatic logic [CW-1:0] limit_of(input logic [2:0] sel);
        logic [63:0] span;
        span = (64'h1 << (hwdt_pkg::BASE_WIDTH + 32'(sel))) - 64'h1;
        return span[CW-1:0];
    endfunction

    // Wake pin synchroniser, idle high
    logic wake_meta_q, wake_meta_d;
    logic wake_sync_q, wake_sync_d;

    always_comb begin
        wake_meta_d = wake_int_n_i;
        wake_sync_d = wake_meta_q;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_meta_q <= 1'b1;
            wake_sync_q <= 1'b1;
        end else begin
            wake_meta_q <= wake_meta_d;
            wake_sync_q <= wake_sync_d;
        end
    end

    hwdt_pkg::hwdt_seq_type seq_q, seq_d;
    logic [2:0] sel_q, sel_d;
    logic en_q, en_d;
    logic hold_q, hold_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [PW-1:0] pulse_q, pulse_d;
    logic svc_wr, sel_wr, restart, overflow, counting;

    assign svc_wr = sfr_i.wr && is_service(sfr_i.addr);
    assign sel_wr = sfr_i.wr && is_select(sfr_i.addr);
    // Second byte completes a sequence armed by the first
    assign restart = svc_wr && (seq_q == hwdt_pkg::HWDT_ARMED) && (sfr_i.wdata == hwdt_pkg::SERVICE_SECOND);
    assign overflow = en_q && (cnt_q == limit_of(sel_q));
    assign counting = en_q && !power_down_i && !hold_q;

    // Service sequence: first byte arms, any other byte drops it
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            hwdt_pkg::HWDT_IDLE: begin
                if (svc_wr && sfr_i.wdata == hwdt_pkg::SERVICE_FIRST) begin
                    seq_d = hwdt_pkg::HWDT_ARMED;
                end
            end
            hwdt_pkg::HWDT_ARMED: begin
                if (svc_wr && sfr_i.wdata != hwdt_pkg::SERVICE_FIRST) begin
                    seq_d = hwdt_pkg::HWDT_IDLE;
                end
            end
            default: begin
                seq_d = hwdt_pkg::HWDT_IDLE;
            end
        endcase
        // Overflow acts as a device reset
        if (overflow) begin
            seq_d = hwdt_pkg::HWDT_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_q <= hwdt_pkg::HWDT_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // Timeout select and enable; overflow clears both
    always_comb begin
        sel_d = sel_q;
        en_d = en_q;
        if (sel_wr) begin
            sel_d = sfr_i.wdata[2:0];
        end
        if (restart) begin
            en_d = 1'b1;
        end
        if (overflow) begin
            sel_d = hwdt_pkg::SELECT_RESET;
            en_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_q <= hwdt_pkg::SELECT_RESET;
            en_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            en_q <= en_d;
        end
    end

    // Power-down freezes counting until the synced wake pin is high again
    always_comb begin
        hold_d = hold_q;
        if (power_down_i) begin
            hold_d = 1'b1;
        end else if (wake_sync_q) begin
            hold_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
        end
    end

    // Counter restarts on service and after overflow
    always_comb begin
        cnt_d = cnt_q;
        if (restart || overflow) begin
            cnt_d = '0;
        end else if (counting) begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Reset pulse length counter; output low while nonzero
    always_comb begin
        pulse_d = pulse_q;
        if (overflow) begin
            pulse_d = PW'(PULSE_CYCLES);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - PW'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_q <= '0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // Read path: select register only; service reads zero
    always_comb begin
        sfr_rdata_o = 8'h00;
        sfr_hit_o = 1'b0;
        if (is_select(sfr_i.addr)) begin
            sfr_rdata_o = {5'h00, sel_q};
            sfr_hit_o = 1'b1;
        end else if (is_service(sfr_i.addr)) begin
            sfr_hit_o = 1'b1;
        end
    end

    assign enabled_o = en_q;
    assign wdt_reset_n_o = (pulse_q == '0);
endmodule

/* hwdt_pkg.sv */
// Constants and types shared by the hardware watchdog
package hwdt_pkg;
    localparam logic [7:0] SERVICE_ADDR = 8'hA6;
    localparam logic [7:0] SELECT_ADDR = 8'hA7;
    localparam logic [7:0] SERVICE_FIRST = 8'h1E;
    localparam logic [7:0] SERVICE_SECOND = 8'hE1;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam int BASE_WIDTH = 14;
    localparam int PRESCALE_WIDTH = 7;
    localparam int RESET_PULSE_CYCLES = 96;
    localparam int PULSE_CNT_WIDTH = 7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hwdt_sfr_type;

    typedef enum logic [1:0] {
        HWDT_IDLE,
        HWDT_ARMED
    } hwdt_seq_type;
endpackage

/* testbench.sv */
// Self-checking bench for the hardware watchdog
`timescale 1ns/10ps
module testbench;
    logic core_clk_i, arst_n_i, power_down_i, wake_int_n_i, sfr_hit_o, enabled_o, wdt_reset_n_o;
    logic [7:0] sfr_rdata_o;
    hwdt_pkg::hwdt_sfr_type sfr_i;
    int fail_count = 0, num_checks = 0, n;
    logic [23:0] rows [10] = '{24'hA70101, 24'hA70202, 24'hA70303, 24'hA70404, 24'hA70505,
        24'hA70606, 24'hA70707, 24'hA61E00, 24'h55AA00, 24'hA70000};
    hwdt_core uut (.core_clk_i, .arst_n_i, .sfr_i, .power_down_i, .wake_int_n_i, .sfr_rdata_o, .sfr_hit_o,
        .enabled_o, .wdt_reset_n_o);
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    task automatic w(input logic [7:0] a, d);
        cyc(1);
        sfr_i = '{1'b1, 1'b0, a, d};
        cyc(1);
        sfr_i.wr = 1'b0;
    endtask
    task automatic svc();
        w(8'hA6, 8'h1E);
        w(8'hA6, 8'hE1);
    endtask
    initial begin
        arst_n_i = 1'b0;
        sfr_i = '{1'b0, 1'b0, 8'hA7, 8'h00};
        power_down_i = 1'b0;
        wake_int_n_i = 1'b1;
        cyc(2);
        arst_n_i = 1'b1;
        chk({enabled_o, wdt_reset_n_o, sfr_rdata_o}, 16'h0100);
        foreach (rows[i]) begin
            w(rows[i][23:16], rows[i][15:8]);
            chk({sfr_hit_o, sfr_rdata_o}, {rows[i][23:17] == 7'h53, rows[i][7:0]});
        end
        w(8'hA6, 8'h55);
        w(8'hA6, 8'hE1);
        chk(enabled_o, 1'b0);
        w(8'hA6, 8'h1E);
        w(8'hA7, 8'h00);
        w(8'hA6, 8'hE1);
        chk(enabled_o, 1'b1);
        repeat (2) begin
            cyc(10000);
            chk({enabled_o, wdt_reset_n_o}, 2'h3);
            svc();
        end
        power_down_i = 1'b1;
        cyc(16500);
        chk({enabled_o, wdt_reset_n_o}, 2'h3);
        wake_int_n_i = 1'b0;
        cyc(3);
        power_down_i = 1'b0;
        cyc(16500);
        chk({enabled_o, wdt_reset_n_o}, 2'h3);
        wake_int_n_i = 1'b1;
        cyc(3);
        svc();
        for (n = 0; wdt_reset_n_o !== 1'b0 && n < 40000; n++)
            cyc(1);
        chk(16'(n), 16'h4000);
        for (n = 0; wdt_reset_n_o === 1'b0 && n < 200; n++)
            cyc(1);
        chk(16'(n), 16'h0060);
        chk(enabled_o, 1'b0);
        w(8'hA7, 8'h05);
        svc();
        sfr_i.addr = 8'hA7;
        cyc(1);
        chk({enabled_o, wdt_reset_n_o, sfr_rdata_o}, 16'h0305);
        arst_n_i = 1'b0;
        cyc(2);
        arst_n_i = 1'b1;
        chk({enabled_o, wdt_reset_n_o, sfr_rdata_o}, 16'h0100);
        print_verdict();
    end
endmodule
bind hwdt_core hwdt_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.core_clk_i, .arst_n_i, .sfr_i, .sfr_rdata_o,
    .sfr_hit_o, .enabled_o, .wdt_reset_n_o);
